// ---- include/sfpe_pkg.sv ----
// Purpose: shared constants and types of the flash program/erase sequencer
// Assumes: 100 MHz ref_clk, opcodes and frame lengths counted in bytes
// Notes: protection map decoding lives outside this block
package sfpe_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_US = 1000;

    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;

    localparam logic [9:0] LEN_OPCODE_ONLY = 10'h001;
    localparam logic [9:0] LEN_WITH_ADDR = 10'h004;
    localparam logic [9:0] LEN_PROG_MIN = 10'h005;
    localparam logic [9:0] BYTE_CNT_MAX = 10'h3FF;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam int unsigned PAGE_DEPTH = 256;

    localparam logic [2:0] STEP_SINGLE = 3'h1;
    localparam logic [2:0] STEP_QUAD = 3'h4;
    localparam logic [2:0] BIT_CNT_ZERO = 3'h0;

    typedef enum logic [2:0] {
        SFPE_OP_NONE = 3'h0,
        SFPE_OP_PROG = 3'h1,
        SFPE_OP_SECTOR = 3'h2,
        SFPE_OP_HALF_BLOCK = 3'h3,
        SFPE_OP_BLOCK = 3'h4,
        SFPE_OP_CHIP = 3'h5
    } sfpe_op_t;

    typedef enum logic [3:0] {
        SFPE_IDLE = 4'h1,
        SFPE_RUN = 4'h2,
        SFPE_SUSPENDING = 4'h4,
        SFPE_SUSPENDED = 4'h8
    } sfpe_state_t;

    // busy time in whole cycles, never below one
    function automatic logic [31:0] us_to_cyc(input int unsigned us);
        int unsigned c;
        c = us * (NS_PER_US / CLK_PERIOD_NS);
        return (c == 0) ? 32'h1 : 32'(c);
    endfunction

    // longest time rounds down, never below one cycle
    function automatic logic [31:0] ns_to_cyc_floor(input int unsigned ns);
        int unsigned c;
        c = ns / CLK_PERIOD_NS;
        return (c == 0) ? 32'h1 : 32'(c);
    endfunction
endpackage

// ---- design/sfpe_pin_sync.sv ----
// Purpose: three-stage synchroniser for asynchronous pins
// Assumes: pins may change at any time relative to ref_clk
// Notes: output moves only once stages two and three agree
`timescale 1ns/10ps
module sfpe_pin_sync #(
    parameter int unsigned W = 1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    s1_reg[i] <= 1'b1;
                    s2_reg[i] <= 1'b1;
                    s3_reg[i] <= 1'b1;
                    pin_out[i] <= 1'b1;
                end else begin
                    s1_reg[i] <= pin_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        pin_out[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// ---- design/sfpe_cycle_timer.sv ----
// Purpose: pausable down-counter for self-timed cycles
// Assumes: load and run are same-clock levels
// Notes: holding run low freezes the remaining count, used for suspend
`timescale 1ns/10ps
module sfpe_cycle_timer (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [31:0] load_val,
    input wire logic run,
    output logic done
);
    logic [31:0] remain_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            remain_reg <= 32'h0;
        end else if (load) begin
            remain_reg <= load_val;
        end else if (run && remain_reg != 32'h0) begin
            remain_reg <= remain_reg - 32'h1;
        end
    end

    assign done = run && !load && (remain_reg == 32'h1);
endmodule

// ---- design/sfpe_flash_seq.sv ----
// Purpose: program/erase/suspend command sequencer of a serial flash
// Assumes: host drives spi_sck, spi_cs_n and data lines asynchronously
// Notes: array access is done by an executor fed from op_* outputs
// Contract
// R01 - quad page program only accepted while quad_io_enable is one
// R02 - quad program frame: 32h, 24-bit address, data bytes on four lines; the code also shifts the address in on four lines
// R03 - program at most 256 bytes into an erased page
// R04 - host keeps chip select low while data shifts in
// R05 - 20h plus address erases one 4K-byte sector
// R06 - 52h plus address erases one 32K-byte block
// R07 - D8h plus address erases one 64K-byte block
// R08 - C7h or 60h without address erases the whole array
// R09 - program and erase refused unless write_latch_flag is one
// R10 - execute only if chip select rises on a whole byte boundary
// R11 - busy reads one during the cycle, zero when done
// R12 - write_latch_flag cleared when the cycle completes
// R13 - protected target or any protection blocks the operation
// R14 - suspend accepted only if not suspended and busy on erase/program
// R15 - suspend ignored during chip erase
// R16 - erase and status write refused while an erase is suspended
// R17 - program and status write refused while a program is suspended
// R18 - suspend sets suspended flag at once, busy drops within latency
// R19 - host waits suspend latency after resume before suspending again
// R20 - power loss leaves the device unsuspended, flag zero
// R21 - resume accepted only when suspended and not busy
// R22 - program data past page end wraps to page start
// R23 - bits shift msb first on rising clock while chip select low
`timescale 1ns/10ps
module sfpe_flash_seq #(
    parameter int unsigned PROG_TIME_US = 800,
    parameter int unsigned SECTOR_ERASE_TIME_US = 60000,
    parameter int unsigned HALF_BLOCK_ERASE_TIME_US = 120000,
    parameter int unsigned BLOCK_ERASE_TIME_US = 150000,
    parameter int unsigned FULL_ERASE_TIME_US = 1000000,
    parameter int unsigned SUSPEND_LATENCY_NS = 20000
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic data_line0,
    input wire logic data_line1,
    input wire logic data_line2,
    input wire logic data_line3,
    input wire logic quad_io_enable,
    input wire logic frame_addr_protected,
    input wire logic any_area_protected,
    input wire logic [7:0] buf_rd_idx,
    output logic [23:0] frame_addr,
    output logic busy_flag,
    output logic write_latch_flag,
    output logic suspended_flag,
    output logic status_write_allowed,
    output logic op_start,
    output logic op_done,
    output sfpe_pkg::sfpe_op_t op_kind,
    output logic [23:0] op_addr,
    output logic [8:0] op_count,
    output logic [7:0] buf_rd_data
);
    localparam logic [31:0] SUS_CYC =
        sfpe_pkg::ns_to_cyc_floor(SUSPEND_LATENCY_NS);

    logic sck_f;
    logic cs_n_f;
    logic [3:0] dl_f;
    logic sck_prev_reg;
    logic cs_prev_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [9:0] byte_cnt_reg;
    logic [7:0] opcode_reg;
    logic [23:0] addr_reg;
    logic [8:0] data_cnt_reg;
    logic quad_reg;
    logic [7:0] page_buf [sfpe_pkg::PAGE_DEPTH];
    sfpe_pkg::sfpe_state_t st_reg;
    sfpe_pkg::sfpe_state_t st_next;
    logic wel_reg;

    sfpe_pin_sync #(
        .W(6)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_in({spi_sck, spi_cs_n, data_line3, data_line2, data_line1,
                 data_line0}),
        .pin_out({sck_f, cs_n_f, dl_f})
    );

    // command decode used for both the start check and the busy time
    function automatic sfpe_pkg::sfpe_op_t op_decode(input logic [7:0] op,
                                                     input logic quad_ok);
        case (op)
            sfpe_pkg::OP_QUAD_PROG:
                return quad_ok ? sfpe_pkg::SFPE_OP_PROG
                               : sfpe_pkg::SFPE_OP_NONE;
            sfpe_pkg::OP_SECTOR_ERASE: return sfpe_pkg::SFPE_OP_SECTOR;
            sfpe_pkg::OP_HALF_BLOCK_ERASE: return sfpe_pkg::SFPE_OP_HALF_BLOCK;
            sfpe_pkg::OP_BLOCK_ERASE: return sfpe_pkg::SFPE_OP_BLOCK;
            sfpe_pkg::OP_CHIP_ERASE_A: return sfpe_pkg::SFPE_OP_CHIP;
            sfpe_pkg::OP_CHIP_ERASE_B: return sfpe_pkg::SFPE_OP_CHIP;
            default: return sfpe_pkg::SFPE_OP_NONE;
        endcase
    endfunction

    // frame sampling
    wire sck_rise = sck_f && !sck_prev_reg && !cs_n_f; // R23
    wire cs_rise = cs_n_f && !cs_prev_reg;
    wire [2:0] step = quad_reg ? sfpe_pkg::STEP_QUAD : sfpe_pkg::STEP_SINGLE;
    wire [2:0] bit_cnt_next = bit_cnt_reg + step;
    wire byte_done = sck_rise && (bit_cnt_next == sfpe_pkg::BIT_CNT_ZERO);
    wire [7:0] shift_next = quad_reg ? {shift_reg[3:0], dl_f}
                                     : {shift_reg[6:0], dl_f[0]}; // R23
    wire is_opcode_byte = (byte_cnt_reg == 10'h000);
    wire is_addr_byte = (byte_cnt_reg != 10'h000)
                     && (byte_cnt_reg < sfpe_pkg::LEN_WITH_ADDR);
    wire [9:0] data_pos = byte_cnt_reg - sfpe_pkg::LEN_WITH_ADDR;
    wire [7:0] page_idx = addr_reg[7:0] + data_pos[7:0]; // R22
    wire suspended_any = (st_reg == sfpe_pkg::SFPE_SUSPENDING)
                      || (st_reg == sfpe_pkg::SFPE_SUSPENDED);
    wire buf_wr = byte_done && !is_opcode_byte && !is_addr_byte
               && quad_reg && (st_reg == sfpe_pkg::SFPE_IDLE);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sck_prev_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_f;
            cs_prev_reg <= cs_n_f;
        end
    end

    // chip select high restarts the frame; a partial byte is left behind
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            byte_cnt_reg <= 10'h000;
            opcode_reg <= 8'h00;
            addr_reg <= 24'h000000;
            data_cnt_reg <= 9'h000;
            quad_reg <= 1'b0;
        end else if (cs_n_f) begin
            if (cs_rise) begin
                quad_reg <= 1'b0;
            end else begin
                bit_cnt_reg <= 3'h0;
                byte_cnt_reg <= 10'h000;
                data_cnt_reg <= 9'h000;
            end
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            if (byte_done) begin
                if (byte_cnt_reg != sfpe_pkg::BYTE_CNT_MAX) begin
                    byte_cnt_reg <= byte_cnt_reg + 10'h001;
                end
                if (is_opcode_byte) begin
                    opcode_reg <= shift_next;
                    // only an enabled quad program switches lanes
                    quad_reg <= (shift_next == sfpe_pkg::OP_QUAD_PROG)
                             && quad_io_enable; // R01 R02
                end else if (is_addr_byte) begin
                    addr_reg <= {addr_reg[15:0], shift_next}; // R02
                end else if (data_cnt_reg != sfpe_pkg::PAGE_BYTES) begin
                    data_cnt_reg <= data_cnt_reg + 9'h001; // R03
                end
            end
        end
    end

    // page buffer; later bytes for the same slot overwrite earlier ones
    always_ff @(posedge ref_clk) begin
        if (buf_wr) begin
            page_buf[page_idx] <= shift_next; // R22 R04
        end
    end

    // end-of-frame decisions
    wire whole_bytes = (bit_cnt_reg == sfpe_pkg::BIT_CNT_ZERO); // R10
    sfpe_pkg::sfpe_op_t frame_op;
    assign frame_op = op_decode(opcode_reg, quad_io_enable); // R01
    wire len_ok =
        (frame_op == sfpe_pkg::SFPE_OP_PROG)
            ? (byte_cnt_reg >= sfpe_pkg::LEN_PROG_MIN)
            : (frame_op == sfpe_pkg::SFPE_OP_CHIP)
                ? (byte_cnt_reg == sfpe_pkg::LEN_OPCODE_ONLY) // R08
                : (byte_cnt_reg == sfpe_pkg::LEN_WITH_ADDR); // R05 R06 R07
    wire target_locked = (frame_op == sfpe_pkg::SFPE_OP_CHIP)
                       ? any_area_protected : frame_addr_protected; // R13
    wire frame_end = cs_rise && whole_bytes; // R10
    wire one_byte = (byte_cnt_reg == sfpe_pkg::LEN_OPCODE_ONLY);
    // idle-only start: suspended states refuse every program/erase
    wire start_ok = frame_end && len_ok && wel_reg && !target_locked
                 && (frame_op != sfpe_pkg::SFPE_OP_NONE)
                 && (st_reg == sfpe_pkg::SFPE_IDLE); // R09 R13 R16 R17
    wire suspend_ok = frame_end && one_byte
                   && (opcode_reg == sfpe_pkg::OP_SUSPEND)
                   && (st_reg == sfpe_pkg::SFPE_RUN)
                   && (op_kind != sfpe_pkg::SFPE_OP_CHIP); // R14 R15
    wire resume_ok = frame_end && one_byte
                  && (opcode_reg == sfpe_pkg::OP_RESUME)
                  && (st_reg == sfpe_pkg::SFPE_SUSPENDED); // R21
    wire wel_set = frame_end && one_byte
                && (opcode_reg == sfpe_pkg::OP_WRITE_ENABLE)
                && !busy_flag;

    wire [31:0] busy_cyc =
        (frame_op == sfpe_pkg::SFPE_OP_PROG)
            ? sfpe_pkg::us_to_cyc(PROG_TIME_US)
        : (frame_op == sfpe_pkg::SFPE_OP_SECTOR)
            ? sfpe_pkg::us_to_cyc(SECTOR_ERASE_TIME_US)
        : (frame_op == sfpe_pkg::SFPE_OP_HALF_BLOCK)
            ? sfpe_pkg::us_to_cyc(HALF_BLOCK_ERASE_TIME_US)
        : (frame_op == sfpe_pkg::SFPE_OP_BLOCK)
            ? sfpe_pkg::us_to_cyc(BLOCK_ERASE_TIME_US)
            : sfpe_pkg::us_to_cyc(FULL_ERASE_TIME_US);

    logic op_timer_done;
    logic sus_timer_done;

    // the operation timer keeps its count across a suspend
    sfpe_cycle_timer u_op_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .load(start_ok),
        .load_val(busy_cyc),
        .run(st_reg == sfpe_pkg::SFPE_RUN),
        .done(op_timer_done)
    );

    sfpe_cycle_timer u_sus_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .load(suspend_ok),
        .load_val(SUS_CYC),
        .run(st_reg == sfpe_pkg::SFPE_SUSPENDING),
        .done(sus_timer_done)
    );

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            sfpe_pkg::SFPE_IDLE: begin
                if (start_ok) begin
                    st_next = sfpe_pkg::SFPE_RUN; // R11
                end
            end
            sfpe_pkg::SFPE_RUN: begin
                // completion first: a suspend would freeze a spent timer
                if (op_timer_done) begin
                    st_next = sfpe_pkg::SFPE_IDLE; // R11
                end else if (suspend_ok) begin
                    st_next = sfpe_pkg::SFPE_SUSPENDING; // R18
                end
            end
            sfpe_pkg::SFPE_SUSPENDING: begin
                if (sus_timer_done) begin
                    st_next = sfpe_pkg::SFPE_SUSPENDED; // R18
                end
            end
            sfpe_pkg::SFPE_SUSPENDED: begin
                if (resume_ok) begin
                    st_next = sfpe_pkg::SFPE_RUN; // R21
                end
            end
            default: st_next = sfpe_pkg::SFPE_IDLE;
        endcase
    end

    // reset stands for power-up: any suspension is dropped
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= sfpe_pkg::SFPE_IDLE; // R20
            wel_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            if (op_timer_done && st_reg == sfpe_pkg::SFPE_RUN) begin
                wel_reg <= 1'b0; // R12
            end else if (wel_set) begin
                wel_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            op_start <= 1'b0;
            op_done <= 1'b0;
            op_kind <= sfpe_pkg::SFPE_OP_NONE;
            op_addr <= 24'h000000;
            op_count <= 9'h000;
            buf_rd_data <= 8'h00;
        end else begin
            op_start <= start_ok;
            op_done <= op_timer_done && (st_reg == sfpe_pkg::SFPE_RUN);
            buf_rd_data <= page_buf[buf_rd_idx];
            if (start_ok) begin
                op_kind <= frame_op; // R05 R06 R07 R08
                op_addr <= addr_reg;
                op_count <= data_cnt_reg; // R03
            end
        end
    end

    assign frame_addr = addr_reg;
    assign write_latch_flag = wel_reg;
    assign busy_flag = (st_reg == sfpe_pkg::SFPE_RUN)
                    || (st_reg == sfpe_pkg::SFPE_SUSPENDING); // R11 R18
    assign suspended_flag = suspended_any; // R18
    assign status_write_allowed = !suspended_any; // R16 R17

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    logic [31:0] sus_wait_reg;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sus_wait_reg <= 32'h0;
        end else if (st_reg == sfpe_pkg::SFPE_SUSPENDING) begin
            sus_wait_reg <= sus_wait_reg + 32'h1;
        end else begin
            sus_wait_reg <= 32'h0;
        end
    end

    sequence s_enter_suspend;
        !suspended_flag ##1 suspended_flag;
    endsequence

    sequence s_resume;
        (st_reg == sfpe_pkg::SFPE_SUSPENDED) ##1
        (st_reg == sfpe_pkg::SFPE_RUN);
    endsequence

    chk_quad_needs_enable: assert property ( // R01
        op_start && op_kind == sfpe_pkg::SFPE_OP_PROG
        |-> $past(quad_io_enable))
        else $error("quad program started without quad enable");
    chk_start_needs_latch: assert property ( // R09
        op_start |-> $past(write_latch_flag))
        else $error("operation started without write latch");
    chk_start_on_boundary: assert property ( // R10
        op_start |-> $past(cs_rise) && $past(whole_bytes))
        else $error("operation started off a byte boundary");
    chk_busy_follows_start: assert property ( // R11
        op_start |-> busy_flag)
        else $error("busy not set after start");
    chk_latch_clear_done: assert property ( // R12
        op_done |-> !write_latch_flag && !busy_flag)
        else $error("write latch or busy left set at completion");
    chk_page_limit: assert property ( // R03
        op_start |-> op_count <= sfpe_pkg::PAGE_BYTES)
        else $error("program count beyond one page");
    chk_suspend_entry: assert property ( // R14
        s_enter_suspend |-> $past(busy_flag) && busy_flag
                         && op_kind != sfpe_pkg::SFPE_OP_CHIP)
        else $error("suspend accepted while idle or on chip erase");
    chk_no_chip_suspend: assert property ( // R15
        op_kind == sfpe_pkg::SFPE_OP_CHIP && busy_flag |-> !suspended_flag)
        else $error("chip erase was suspended");
    chk_suspend_latency: assert property ( // R18
        suspended_flag && busy_flag |-> sus_wait_reg < SUS_CYC)
        else $error("busy held beyond the suspend latency");
    chk_no_start_suspended: assert property ( // R16
        op_start |-> !$past(suspended_flag))
        else $error("operation started while suspended");
    chk_resume_state: assert property ( // R21
        s_resume |-> !suspended_flag && busy_flag)
        else $error("resume left flags wrong");
endmodule

// ---- verification/sfpe_host_model.sv ----
// Purpose: host SPI controller model driving the flash sequencer pins
// Assumes: called from the bench at ref_clk falling edges
// Notes: sck stands low between frames, idle data lines keep flipping
`timescale 1ns/10ps
module sfpe_host_model (
    input wire logic ref_clk,
    output logic spi_sck,
    output logic spi_cs_n,
    output logic [3:0] data_lines
);
    localparam int HALF = 5;
    initial begin
        spi_sck = 1'h0;
        spi_cs_n = 1'h1;
        data_lines = 4'hA;
    end
    task automatic half_wait();
        repeat (HALF) @(negedge ref_clk);
    endtask
    // msb first, quad lanes carry data_line3 as the upper bit
    task automatic shift(input logic [7:0] b, input bit quad, input int nb);
        int i;
        for (i = 0; i < nb; i += (quad ? 4 : 1)) begin
            data_lines = quad ? b[7-i -: 4] : {~data_lines[3:1], b[7-i]};
            half_wait();
            spi_sck = 1'h1;
            half_wait();
            spi_sck = 1'h0;
        end
    endtask
    // extra of 1 to 7 appends a partial byte so the frame must be discarded
    task automatic send(input logic [7:0] op, input bit wa,
                        input logic [23:0] addr, input int nd,
                        input bit quad, input int extra);
        int n;
        @(negedge ref_clk);
        spi_cs_n = 1'h0;
        half_wait();
        shift(op, 1'h0, 8);
        if (wa)
            for (n = 2; n >= 0; n--) shift(addr[n*8 +: 8], quad, 8);
        for (n = 0; n < nd; n++) shift(n[8:1], quad, 8);
        if (extra > 0) shift(8'hFF, 1'h0, extra);
        half_wait();
        spi_cs_n = 1'h1;
        data_lines = ~data_lines;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule

// ---- verification/serial_flash_program_erase_tb.sv ----
// Purpose: self-checking bench of the program/erase sequencer
// Assumes: shortened cycle times, default suspend latency
// Notes: refused program/erase frames are judged by the absence of op_start, refused suspends by suspended_flag
`timescale 1ns/10ps
module serial_flash_program_erase_tb;
    typedef struct {
        logic [7:0] op;
        bit wa;
        int nd;
        logic qe, fp, ap;
        logic [2:0] kind;
        logic st;
    } sfpe_row_t;
    localparam logic [23:0] ADDR = 24'h012345;
    logic ref_clk = 1'h0, rstn = 1'h0;
    logic quad_io_enable = 1'h0, frame_addr_protected = 1'h0;
    logic any_area_protected = 1'h0;
    logic [7:0] buf_rd_idx = 8'h00;
    logic spi_sck, spi_cs_n;
    logic [3:0] dl;
    logic [23:0] frame_addr, op_addr;
    logic busy_flag, write_latch_flag, suspended_flag, status_write_allowed;
    logic op_start, op_done;
    sfpe_pkg::sfpe_op_t op_kind;
    logic [8:0] op_count;
    logic [7:0] buf_rd_data;
    int mismatches = 0, samples_checked = 0;
    sfpe_row_t rows [0:8];
    logic seen;
    int cnt [2] = '{0, 0}, mark [2] = '{0, 0};
    always #5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        cnt[0] += op_start;
        cnt[1] += op_done;
    end
    sfpe_host_model host (.ref_clk(ref_clk), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .data_lines(dl));
    sfpe_flash_seq #(.PROG_TIME_US(1), .SECTOR_ERASE_TIME_US(2),
        .HALF_BLOCK_ERASE_TIME_US(3), .BLOCK_ERASE_TIME_US(4),
        .FULL_ERASE_TIME_US(5)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .data_line0(dl[0]), .data_line1(dl[1]),
        .data_line2(dl[2]), .data_line3(dl[3]),
        .quad_io_enable(quad_io_enable),
        .frame_addr_protected(frame_addr_protected),
        .any_area_protected(any_area_protected), .buf_rd_idx(buf_rd_idx),
        .frame_addr(frame_addr), .busy_flag(busy_flag),
        .write_latch_flag(write_latch_flag), .suspended_flag(suspended_flag),
        .status_write_allowed(status_write_allowed), .op_start(op_start),
        .op_done(op_done), .op_kind(op_kind), .op_addr(op_addr),
        .op_count(op_count), .buf_rd_data(buf_rd_data));
    task automatic check(input logic [23:0] s, input logic [23:0] e,
                         input string msg);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s seen %h want %h", $time, msg, s, e);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d samples_checked %0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // pulses are counted at falling edges, so one already past is seen
    task automatic wait_pulse(input bit done_pulse, input int lim);
        int k;
        seen = 1'h0;
        for (k = 0; k < lim && !seen; k++) begin
            @(posedge ref_clk);
            seen = cnt[done_pulse] != mark[done_pulse];
        end
        mark[done_pulse] = cnt[done_pulse];
        @(negedge ref_clk);
    endtask
    task automatic wen();
        host.send(sfpe_pkg::OP_WRITE_ENABLE, 0, 24'h0, 0, 0, 0);
    endtask
    task automatic sector_then_suspend();
        wen();
        host.send(sfpe_pkg::OP_SECTOR_ERASE, 1, ADDR, 0, 0, 0);
        wait_pulse(0, 30);
        host.send(sfpe_pkg::OP_SUSPEND, 0, 24'h0, 0, 0, 0);
    endtask
    initial begin
        int r;
        rows[0] = '{8'h20, 1, 0, 1'h0, 1'h0, 1'h0, 3'h2, 1'h1};
        rows[1] = '{8'h52, 1, 0, 1'h0, 1'h0, 1'h0, 3'h3, 1'h1};
        rows[2] = '{8'hD8, 1, 0, 1'h0, 1'h0, 1'h0, 3'h4, 1'h1};
        rows[3] = '{8'hC7, 0, 0, 1'h0, 1'h0, 1'h0, 3'h5, 1'h1};
        rows[4] = '{8'h60, 0, 0, 1'h0, 1'h0, 1'h0, 3'h5, 1'h1};
        rows[5] = '{8'h20, 1, 0, 1'h0, 1'h1, 1'h0, 3'h0, 1'h0};
        rows[6] = '{8'hC7, 0, 0, 1'h0, 1'h0, 1'h1, 3'h0, 1'h0};
        rows[7] = '{8'h32, 1, 2, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0};
        rows[8] = '{8'h32, 1, 2, 1'h1, 1'h0, 1'h0, 3'h1, 1'h1};
        repeat (5) @(negedge ref_clk);
        check(busy_flag, 0, "busy after reset");
        check(status_write_allowed, 1, "status write after reset");
        rstn = 1'h1;
        repeat (5) @(negedge ref_clk);
        for (r = 0; r < 9; r++) begin
            quad_io_enable = rows[r].qe;
            frame_addr_protected = rows[r].fp;
            any_area_protected = rows[r].ap;
            wen();
            check(write_latch_flag, 1, "latch after enable");
            host.send(rows[r].op, rows[r].wa, ADDR, rows[r].nd,
                      rows[r].op == sfpe_pkg::OP_QUAD_PROG, 0);
            wait_pulse(0, 30);
            check(seen, rows[r].st, "start");
            if (rows[r].st) begin
                check(op_kind, rows[r].kind, "kind");
                check(busy_flag, 1, "busy at start");
                if (rows[r].wa) check(op_addr, ADDR, "addr");
                if (rows[r].wa) check(frame_addr, ADDR, "frame");
                if (rows[r].nd > 0) check(op_count, 2, "count");
                wait_pulse(1, 1000);
                check(seen, 1, "done");
                check(write_latch_flag, 0, "latch cleared");
                check(busy_flag, 0, "busy cleared");
            end
        end
        frame_addr_protected = 1'h0;
        any_area_protected = 1'h0;
        host.send(sfpe_pkg::OP_SECTOR_ERASE, 1, ADDR, 0, 0, 0);
        wait_pulse(0, 30);
        check(seen, 0, "erase without latch");
        wen();
        host.send(sfpe_pkg::OP_SECTOR_ERASE, 1, ADDR, 0, 0, 3);
        wait_pulse(0, 30);
        check(seen, 0, "partial byte");
        host.send(sfpe_pkg::OP_SUSPEND, 0, 24'h0, 0, 0, 0);
        check(suspended_flag, 0, "suspend while idle");
        sector_then_suspend();
        check(suspended_flag, 1, "suspend taken");
        repeat (2005) @(negedge ref_clk);
        check(busy_flag, 0, "busy after latency");
        check(status_write_allowed, 0, "status write refused");
        host.send(sfpe_pkg::OP_SECTOR_ERASE, 1, ADDR, 0, 0, 0);
        wait_pulse(0, 30);
        check(seen, 0, "erase while suspended");
        host.send(sfpe_pkg::OP_RESUME, 0, 24'h0, 0, 0, 0);
        check(suspended_flag, 0, "resume clears flag");
        check(busy_flag, 1, "resume busy");
        wait_pulse(1, 1000);
        check(write_latch_flag, 0, "latch after resumed erase");
        wen();
        host.send(sfpe_pkg::OP_CHIP_ERASE_A, 0, 24'h0, 0, 0, 0);
        wait_pulse(0, 30);
        host.send(sfpe_pkg::OP_SUSPEND, 0, 24'h0, 0, 0, 0);
        check(suspended_flag, 0, "suspend in chip erase");
        wait_pulse(1, 1000);
        wen();
        host.send(sfpe_pkg::OP_QUAD_PROG, 1, 24'h000210, 257, 1, 0);
        wait_pulse(0, 30);
        check(op_count, 9'h100, "count saturates");
        wait_pulse(1, 1000);
        buf_rd_idx = 8'h10;
        @(negedge ref_clk);
        buf_rd_idx = 8'h12;
        check(buf_rd_data, 8'h80, "wrapped byte");
        @(negedge ref_clk);
        check(buf_rd_data, 8'h01, "byte two");
        sector_then_suspend();
        rstn = 1'h0;
        repeat (5) @(negedge ref_clk);
        check(suspended_flag, 0, "suspend lost at reset");
        check(busy_flag, 0, "busy lost at reset");
        rstn = 1'h1;
        repeat (5) @(negedge ref_clk);
        test_done();
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        test_done();
    end
endmodule
